// ===== shared/tmv_pkg.sv
// Shared constants and field layouts for the timer control and status block
package tmv_pkg;

   // ----------------------------------------------------------------
   // Register indices and byte addresses (byte address = 4 x index)
   // ----------------------------------------------------------------
   localparam logic [31:0] IDX_CTRL0  = 32'h0000_ffa0;
   localparam logic [31:0] IDX_STATUS = 32'h0000_ffa1;
   localparam logic [31:0] IDX_CTRL1  = 32'h0000_ffa5;
   localparam logic [31:0] IDX_COUNT  = 32'h0000_ffa8;
   localparam logic [31:0] IDX_CMPA   = 32'h0000_ffa9;
   localparam logic [31:0] IDX_CMPB   = 32'h0000_ffaa;
   localparam logic [31:0] IDX_IRQSTA = 32'h0000_ffab;
   localparam logic [31:0] IDX_IRQMSK = 32'h0000_ffac;
   localparam logic [31:0] ADDR_CTRL0  = IDX_CTRL0 << 2;
   localparam logic [31:0] ADDR_STATUS = IDX_STATUS << 2;
   localparam logic [31:0] ADDR_CTRL1  = IDX_CTRL1 << 2;
   localparam logic [31:0] ADDR_COUNT  = IDX_COUNT << 2;
   localparam logic [31:0] ADDR_CMPA   = IDX_CMPA << 2;
   localparam logic [31:0] ADDR_CMPB   = IDX_CMPB << 2;
   localparam logic [31:0] ADDR_IRQSTA = IDX_IRQSTA << 2;
   localparam logic [31:0] ADDR_IRQMSK = IDX_IRQMSK << 2;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int FLAG_POS_B = 7;
   localparam int FLAG_POS_A = 6;
   localparam int FLAG_POS_OV = 5;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] RST_FLAGS = 3'h0;
   localparam logic [7:0] COUNT_TOP = 8'hff;

   // ----------------------------------------------------------------
   // Field encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OS_KEEP   = 2'h0,
      OS_LOW    = 2'h1,
      OS_HIGH   = 2'h2,
      OS_TOGGLE = 2'h3
   } tmv_os_t;

   typedef enum logic [1:0] {
      CLR_NONE  = 2'h0,
      CLR_MATCH_A = 2'h1,
      CLR_MATCH_B = 2'h2,
      CLR_TRIG  = 2'h3
   } tmv_clr_t;

   typedef enum logic [1:0] {
      EDGE_OFF  = 2'h0,
      EDGE_RISE = 2'h1,
      EDGE_FALL = 2'h2,
      EDGE_BOTH = 2'h3
   } tmv_edge_t;

   // ----------------------------------------------------------------
   // Register layouts
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       matchBIrqEnable;
      logic       matchAIrqEnable;
      logic       overflowIrqEnable;
      tmv_clr_t   clearSelect;
      logic [2:0] clockSelect;
   } tmv_ctrl0_t;

   typedef struct packed {
      logic [2:0] unused;
      tmv_edge_t  triggerEdge;
      logic       triggerInputEnable;
      logic       unused0;
      logic       internalClockSelect;
   } tmv_ctrl1_t;

endpackage

// ===== design/tmv_timer.sv
// Timer control, status, compare, trigger and interrupt logic on AHB-Lite
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module tmv_timer (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        triggerInputPin,
   output logic             timerOutputPin,
   output logic             matchAReq,
   output logic             matchBReq,
   output logic             overflowReq,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Falling edge of prescaler bit e-1 happens when the low e bits wrap
   function automatic logic divTick(input logic [7:0] p,
                                    input logic [2:0] cks,
                                    input logic       icks);
      logic [2:0] e;
      logic [7:0] m;
      e = {cks[1:0], 1'b0} + {2'b00, icks};
      m = 8'((9'h001 << e) - 9'h001);
      if (cks == 3'h0 || cks[2]) begin
         return 1'b0;
      end
      return (p & m) == 8'h00;
   endfunction

   function automatic logic applyOs(input logic cur, input logic [1:0] os);
      unique case (os)
         tmv_pkg::OS_KEEP:   return cur;
         tmv_pkg::OS_LOW:    return 1'b0;
         tmv_pkg::OS_HIGH:   return 1'b1;
         tmv_pkg::OS_TOGGLE: return ~cur;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   tmv_pkg::tmv_ctrl0_t ctrl0;
   tmv_pkg::tmv_ctrl1_t ctrl1;
   logic [2:0]          flags;    // {match B, match A, overflow}
   logic [2:0]          armed;    // Flag seen as 1 by a status read
   logic [1:0]          osB;
   logic [1:0]          osA;
   logic [7:0]          counter;
   logic [7:0]          cmpA;
   logic [7:0]          cmpB;
   logic [7:0]          presc;
   logic                running;
   logic                trigPrev;
   logic [2:0]          irqStatus;
   logic [2:0]          irqMask;
   logic                dWrite;
   logic [31:0]         dAddr;

   logic                take;
   logic                tick;
   logic                countOn;
   logic                trigEdge;
   logic                matchA;
   logic                matchB;
   logic                overflow;
   logic                clrMatch;
   logic                wrCtrl0;
   logic                wrStatus;
   logic                wrCtrl1;
   logic                wrCount;
   logic [2:0]          events;
   logic [2:0]          enables;
   logic [2:0]          flagClr;
   logic [31:0]         readValue;

   // ----------------------------------------------------------------
   // Bus slave
   // ----------------------------------------------------------------
   // Zero wait states, so the address phase is taken whenever hready
   assign take = hsel & htrans[1] & hready;
   assign wrCtrl0  = dWrite && dAddr == tmv_pkg::ADDR_CTRL0;
   assign wrStatus = dWrite && dAddr == tmv_pkg::ADDR_STATUS;
   assign wrCtrl1  = dWrite && dAddr == tmv_pkg::ADDR_CTRL1;
   assign wrCount  = dWrite && dAddr == tmv_pkg::ADDR_COUNT;

   // Address phase capture for the write data phase
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dWrite <= 1'b0;
         dAddr  <= 32'h0000_0000;
      end else begin
         dWrite <= take & hwrite;
         if (take) begin
            dAddr <= haddr;
         end
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      readValue = 32'h0000_0000;
      unique case (haddr)
         tmv_pkg::ADDR_CTRL0:  readValue[7:0] = ctrl0;
         tmv_pkg::ADDR_STATUS: readValue[7:0] = {flags, 1'b0, osB, osA};
         tmv_pkg::ADDR_CTRL1:  readValue[7:0] = ctrl1;
         tmv_pkg::ADDR_COUNT:  readValue[7:0] = counter;
         tmv_pkg::ADDR_CMPA:   readValue[7:0] = cmpA;
         tmv_pkg::ADDR_CMPB:   readValue[7:0] = cmpB;
         tmv_pkg::ADDR_IRQSTA: readValue[2:0] = irqStatus;
         tmv_pkg::ADDR_IRQMSK: readValue[2:0] = irqMask;
         default:              readValue = 32'h0000_0000;
      endcase
   end

   // Read data and response, all from flip-flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         hrdata    <= (take & ~hwrite) ? readValue : 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl0 <= tmv_pkg::RST_BYTE;
         ctrl1 <= tmv_pkg::RST_BYTE;
         osB   <= 2'h0;
         osA   <= 2'h0;
         cmpA  <= tmv_pkg::RST_BYTE;
         cmpB  <= tmv_pkg::RST_BYTE;
         irqMask <= 3'h0;
      end else begin
         if (wrCtrl0) begin
            ctrl0 <= hwdata[7:0];
         end
         if (wrCtrl1) begin
            ctrl1 <= {3'h0, hwdata[4:2], 1'b0, hwdata[0]};
         end
         if (wrStatus) begin
            osB <= hwdata[3:2];
            osA <= hwdata[1:0];
         end
         if (dWrite && dAddr == tmv_pkg::ADDR_CMPA) begin
            cmpA <= hwdata[7:0];
         end
         if (dWrite && dAddr == tmv_pkg::ADDR_CMPB) begin
            cmpB <= hwdata[7:0];
         end
         if (dWrite && dAddr == tmv_pkg::ADDR_IRQMSK) begin
            irqMask <= hwdata[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Count clock, trigger and counter
   // ----------------------------------------------------------------
   // Free-running prescaler; one shared divider keeps all rates aligned
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         presc <= 8'h00;
      end else begin
         presc <= presc + 8'h01;
      end
   end

   // Trigger pin edge select; edge field 00 ignores the pin
   always_comb begin
      unique case (ctrl1.triggerEdge)
         tmv_pkg::EDGE_OFF:  trigEdge = 1'b0;
         tmv_pkg::EDGE_RISE: trigEdge = triggerInputPin & ~trigPrev;
         tmv_pkg::EDGE_FALL: trigEdge = ~triggerInputPin & trigPrev;
         tmv_pkg::EDGE_BOTH: trigEdge = triggerInputPin ^ trigPrev;
      endcase
   end

   assign countOn = ctrl1.triggerInputEnable ? running : 1'b1;
   assign tick = countOn & divTick(presc, ctrl0.clockSelect,
                                   ctrl1.internalClockSelect);
   assign matchA = tick && counter == cmpA;
   assign matchB = tick && counter == cmpB;
   assign clrMatch =
      (ctrl0.clearSelect == tmv_pkg::CLR_MATCH_A && matchA) ||
      (ctrl0.clearSelect == tmv_pkg::CLR_MATCH_B && matchB);
   assign overflow = tick && counter == tmv_pkg::COUNT_TOP && !clrMatch;

   // Trigger-gated run state: start on edge, stop on match clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         trigPrev <= 1'b0;
         running  <= 1'b0;
      end else begin
         trigPrev <= triggerInputPin;
         if (!ctrl1.triggerInputEnable) begin
            running <= 1'b0;
         end else if (trigEdge) begin
            running <= 1'b1;
         end else if (clrMatch) begin
            running <= 1'b0;
         end
      end
   end

   // Counter; software write wins over counting
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         counter <= 8'h00;
      end else if (wrCount) begin
         counter <= hwdata[7:0];
      end else if (ctrl0.clearSelect == tmv_pkg::CLR_TRIG && trigEdge) begin
         counter <= 8'h00;
      end else if (tick) begin
         // Clear select 00 never reaches a clear branch
         counter <= clrMatch ? 8'h00 : counter + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   assign events  = {matchB, matchA, overflow};
   assign enables = {ctrl0.matchBIrqEnable, ctrl0.matchAIrqEnable,
                     ctrl0.overflowIrqEnable};
   // Zero write clears only a flag that a read saw as 1
   assign flagClr = {3{wrStatus}} & armed &
                    ~{hwdata[tmv_pkg::FLAG_POS_B], hwdata[tmv_pkg::FLAG_POS_A],
                      hwdata[tmv_pkg::FLAG_POS_OV]};

   // Set wins over clear so a match in the clear cycle survives
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flags <= tmv_pkg::RST_FLAGS;
         armed <= tmv_pkg::RST_FLAGS;
      end else begin
         flags <= events | (flags & ~flagClr);
         if (take && !hwrite && haddr == tmv_pkg::ADDR_STATUS) begin
            armed <= flags;
         end else if (wrStatus) begin
            armed <= 3'h0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Compare output pin
   // ----------------------------------------------------------------
   // B match with a select other than 00 takes priority when both hit in one cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         timerOutputPin <= 1'b0;
      end else if (matchB && osB != tmv_pkg::OS_KEEP) begin
         timerOutputPin <= applyOs(timerOutputPin, osB);
      end else if (matchA) begin
         timerOutputPin <= applyOs(timerOutputPin, osA);
      end
   end

   // ----------------------------------------------------------------
   // Interrupt requests
   // ----------------------------------------------------------------
   // Sticky bit drops with its request; a write of one clears it too
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irqStatus   <= 3'h0;
         matchBReq   <= 1'b0;
         matchAReq   <= 1'b0;
         overflowReq <= 1'b0;
         irq         <= 1'b0;
      end else begin
         irqStatus <= (events & enables) | (irqStatus & flags & enables &
            ~({3{dWrite && dAddr == tmv_pkg::ADDR_IRQSTA}} & hwdata[2:0]));
         matchBReq   <= flags[2] & ctrl0.matchBIrqEnable;
         matchAReq   <= flags[1] & ctrl0.matchAIrqEnable;
         overflowReq <= flags[0] & ctrl0.overflowIrqEnable;
         irq         <= |(irqStatus & irqMask);
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_b_req_block: assert property (@(posedge mclk) disable iff (rst)
      !ctrl0.matchBIrqEnable |=> !matchBReq)
      else $error("match B request with enable low");

   a_a_req_block: assert property (@(posedge mclk) disable iff (rst)
      !ctrl0.matchAIrqEnable |=> !matchAReq)
      else $error("match A request with enable low");

   a_ov_req_gate: assert property (@(posedge mclk) disable iff (rst)
      (ctrl0.overflowIrqEnable && flags[0]) |=> overflowReq)
      else $error("overflow request missing");

   a_no_clear: assert property (@(posedge mclk) disable iff (rst)
      (ctrl0.clearSelect == tmv_pkg::CLR_NONE && !wrCount) |=>
      (counter == $past(counter) || counter == 8'($past(counter) + 8'h01)))
      else $error("counter cleared with clear select off");

   a_div_128: assert property (@(posedge mclk) disable iff (rst)
      (ctrl0.clockSelect == 3'h3 && ctrl1.internalClockSelect && countOn &&
       presc[6:0] == 7'h00 && ctrl0.clearSelect == tmv_pkg::CLR_NONE &&
       !wrCount) |=> counter == 8'($past(counter) + 8'h01))
      else $error("no count at clock/128 edge");

   a_flag_b_set: assert property (@(posedge mclk) disable iff (rst)
      (tick && counter == cmpB) |=> flags[2])
      else $error("match B flag not set");

   a_flag_a_set: assert property (@(posedge mclk) disable iff (rst)
      (tick && counter == cmpA) |=> flags[1])
      else $error("match A flag not set");

   a_ov_set: assert property (@(posedge mclk) disable iff (rst)
      (tick && counter == 8'hff && ctrl0.clearSelect == tmv_pkg::CLR_NONE &&
       !wrCount) |=> flags[0] && counter == 8'h00)
      else $error("overflow flag not set");

   a_ov_clear: assert property (@(posedge mclk) disable iff (rst)
      $fell(flags[0]) |-> $past(wrStatus) && $past(armed[0]) &&
      !$past(hwdata[tmv_pkg::FLAG_POS_OV]))
      else $error("overflow flag cleared without read then zero write");

   a_pin_keep_b: assert property (@(posedge mclk) disable iff (rst)
      (matchB && osB == tmv_pkg::OS_KEEP && !matchA) |=>
      $stable(timerOutputPin))
      else $error("pin changed on B match with select 00");

   a_pin_keep_a: assert property (@(posedge mclk) disable iff (rst)
      (matchA && osA == tmv_pkg::OS_KEEP && !matchB) |=>
      $stable(timerOutputPin))
      else $error("pin changed on A match with select 00");

   a_trig_ignored: assert property (@(posedge mclk) disable iff (rst)
      (ctrl1.triggerEdge == tmv_pkg::EDGE_OFF && !running) |=> !running)
      else $error("trigger pin started counting with edge field 00");

   a_trig_gate: assert property (@(posedge mclk) disable iff (rst)
      (ctrl1.triggerInputEnable && !running && !trigEdge && !wrCount &&
       ctrl0.clearSelect != tmv_pkg::CLR_TRIG) |=> $stable(counter))
      else $error("counter ran before a trigger edge");

   a_req_follow: assert property (@(posedge mclk) disable iff (rst)
      matchAReq |-> $past(flags[1]) && $past(ctrl0.matchAIrqEnable))
      else $error("match A request without flag and enable");

endmodule

// ===== tb/tb_timer_v_control_status.sv
// Self-checking bench for the timer control and status block
`timescale 1ns/1ps
`define CHK(g, e) begin \
   testsRun++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("Error at %0t: got %h expected %h", $time, (g), (e)); \
   end \
end
module tb_timer_v_control_status;
   logic        mclk;
   logic        rst;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   wire logic   hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        trigPin;
   logic        outPin;
   logic        matchAReq;
   logic        matchBReq;
   logic        overflowReq;
   logic        irq;
   logic [31:0] rdSample;
   logic        rdyAtEdge;
   logic [31:0] q;
   logic [7:0]  cmpA;
   logic [7:0]  c1;
   logic [2:0]  cks;
   logic        ick;
   int          k;
   int          fails;
   int          testsRun;
   int          seed;

   // -------------------------------------------------------------
   // Clock, bus and checks
   // -------------------------------------------------------------
   assign hready = hreadyout;

   tmv_timer dut (
      .mclk            (mclk),
      .rst             (rst),
      .hsel            (hsel),
      .haddr           (haddr),
      .htrans          (htrans),
      .hwrite          (hwrite),
      .hsize           (hsize),
      .hwdata          (hwdata),
      .hready          (hready),
      .hreadyout       (hreadyout),
      .hresp           (hresp),
      .hrdata          (hrdata),
      .triggerInputPin (trigPin),
      .timerOutputPin  (outPin),
      .matchAReq       (matchAReq),
      .matchBReq       (matchBReq),
      .overflowReq     (overflowReq),
      .irq             (irq)
   );

   // 250 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   // Bus answer as it stood at the edge, free of update races
   always @(posedge mclk) begin
      rdSample  <= hrdata;
      rdyAtEdge <= hready;
   end

   // Steps land 1 ns after an edge so outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // One whole-word transfer; read data taken at the data-phase edge
   // Waits as long as the slave stalls; only the watchdog ends a hang
   task automatic xfer(input logic wr, input logic [31:0] a,
                       input logic [7:0] d);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do begin
         tick(1);
      end while (rdyAtEdge !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      do begin
         tick(1);
      end while (rdyAtEdge !== 1'b1);
      q = rdSample;
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask

   task automatic rd(input logic [31:0] a);
      xfer(1'b0, a, 8'h00);
   endtask

   // Trigger pin pulse, then time for the counter to react
   task automatic pulse;
      trigPin <= 1'b1;
      tick(2);
      trigPin <= 1'b0;
      tick(60);
   endtask

   // Count clock divider for a clock-select setting
   function automatic int divOf(input logic [2:0] c, input logic i);
      return 1 << (2 * c + i);
   endfunction

   task automatic test_done;
      if (fails == 0 && testsRun > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Hang guard, far beyond the expected run length
   initial begin
      repeat (30000) @(posedge mclk);
      fails++;
      test_done();
   end

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      trigPin = 1'b0;
      seed = 54372;
      fails = 0;
      testsRun = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      tick(1);
      // Reset values; gaps in the map read 0 and ignore writes
      wr(tmv_pkg::ADDR_CTRL0 + 32'h0000_0008, 8'hff);
      for (int i = 0; i < 13; i++) begin
         rd(tmv_pkg::ADDR_CTRL0 + 32'(i * 4));
         `CHK(q, 32'h0000_0000)
         `CHK({hresp, hreadyout}, 2'h1)
      end
      // Match A clears the counter and drives the pin high
      cmpA = 8'h20 + 8'($random(seed) & 32'h0000_007f);
      wr(tmv_pkg::ADDR_STATUS, 8'h02);
      wr(tmv_pkg::ADDR_CMPA, cmpA);
      wr(tmv_pkg::ADDR_CMPB, 8'hf0);
      wr(tmv_pkg::ADDR_COUNT, cmpA - 8'h02);
      wr(tmv_pkg::ADDR_CTRL0, 8'h09);
      tick(40);
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      rd(tmv_pkg::ADDR_COUNT);
      `CHK(q[7:0] < 8'h10, 1'b1)
      `CHK(outPin, 1'b1)
      // Both matches pass with no clearing and the pin left alone
      rd(tmv_pkg::ADDR_STATUS);
      wr(tmv_pkg::ADDR_STATUS, 8'h00);
      wr(tmv_pkg::ADDR_CMPB, cmpA + 8'h01);
      wr(tmv_pkg::ADDR_COUNT, cmpA - 8'h02);
      wr(tmv_pkg::ADDR_CTRL0, 8'h01);
      tick(40);
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      rd(tmv_pkg::ADDR_COUNT);
      `CHK(q[7:0] > cmpA + 8'h01, 1'b1)
      `CHK(outPin, 1'b1)
      rd(tmv_pkg::ADDR_STATUS);
      `CHK(q[7:6], 2'h3)
      `CHK({matchBReq, matchAReq}, 2'h0)
      wr(tmv_pkg::ADDR_CTRL0, 8'hc0);
      tick(3);
      `CHK({matchBReq, matchAReq}, 2'h3)
      wr(tmv_pkg::ADDR_CTRL0, 8'h40);
      tick(3);
      `CHK({matchBReq, matchAReq}, 2'h1)
      wr(tmv_pkg::ADDR_CTRL0, 8'h80);
      tick(3);
      `CHK({matchBReq, matchAReq}, 2'h2)
      // Match B drives the pin low and wins over match A
      wr(tmv_pkg::ADDR_STATUS, 8'h06);
      wr(tmv_pkg::ADDR_CMPB, cmpA);
      wr(tmv_pkg::ADDR_COUNT, cmpA - 8'h02);
      wr(tmv_pkg::ADDR_CTRL0, 8'h01);
      tick(40);
      `CHK(outPin, 1'b0)
      // Trigger edge off, then a rising edge starts a run to match
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      rd(tmv_pkg::ADDR_STATUS);
      wr(tmv_pkg::ADDR_STATUS, 8'h00);
      wr(tmv_pkg::ADDR_CMPA, 8'h03);
      wr(tmv_pkg::ADDR_COUNT, 8'h00);
      wr(tmv_pkg::ADDR_CTRL1, 8'h04);
      wr(tmv_pkg::ADDR_CTRL0, 8'h09);
      pulse();
      rd(tmv_pkg::ADDR_COUNT);
      `CHK(q[7:0], 8'h00)
      rd(tmv_pkg::ADDR_STATUS);
      `CHK(q[6], 1'b0)
      wr(tmv_pkg::ADDR_CTRL1, 8'h0c);
      pulse();
      rd(tmv_pkg::ADDR_COUNT);
      `CHK(q[7:0], 8'h00)
      rd(tmv_pkg::ADDR_STATUS);
      `CHK(q[6], 1'b1)
      // Count rate over an exact window; the first pass is clock/128
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      for (int i = 0; i < 6; i++) begin
         cks = 3'h1 + 3'($unsigned($random(seed)) % 3);
         ick = 1'($random(seed));
         k = 1 + $unsigned($random(seed)) % 3;
         if (i == 0) begin
            cks = 3'h3;
            ick = 1'b1;
         end
         wr(tmv_pkg::ADDR_CTRL1, {7'h00, ick});
         wr(tmv_pkg::ADDR_CTRL0, {5'h00, cks});
         rd(tmv_pkg::ADDR_COUNT);
         c1 = q[7:0];
         tick(divOf(cks, ick) * k - 2);
         rd(tmv_pkg::ADDR_COUNT);
         `CHK(q[7:0] - c1, 8'(k))
      end
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      rd(tmv_pkg::ADDR_COUNT);
      c1 = q[7:0];
      tick(30);
      rd(tmv_pkg::ADDR_COUNT);
      `CHK(q[7:0], c1)
      // Clear on match B holds the count at or below compare B
      wr(tmv_pkg::ADDR_CMPB, 8'h02);
      wr(tmv_pkg::ADDR_COUNT, 8'h00);
      wr(tmv_pkg::ADDR_CTRL0, 8'h11);
      tick(40);
      rd(tmv_pkg::ADDR_COUNT);
      `CHK(q[7:0] < 8'h03, 1'b1)
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      // Overflow flag, its request, the interrupt and the flag clear
      rd(tmv_pkg::ADDR_STATUS);
      wr(tmv_pkg::ADDR_STATUS, 8'h00);
      wr(tmv_pkg::ADDR_CMPA, 8'h50);
      wr(tmv_pkg::ADDR_CMPB, 8'h50);
      wr(tmv_pkg::ADDR_COUNT, 8'hfe);
      wr(tmv_pkg::ADDR_IRQMSK, 8'h01);
      wr(tmv_pkg::ADDR_CTRL0, 8'h21);
      tick(30);
      wr(tmv_pkg::ADDR_CTRL0, 8'h20);
      tick(3);
      `CHK({overflowReq, irq, matchAReq}, 3'h6)
      rd(tmv_pkg::ADDR_IRQSTA);
      `CHK(q[2:0], 3'h1)
      wr(tmv_pkg::ADDR_IRQMSK, 8'h00);
      tick(3);
      `CHK(irq, 1'b0)
      wr(tmv_pkg::ADDR_IRQMSK, 8'h01);
      tick(3);
      `CHK(irq, 1'b1)
      wr(tmv_pkg::ADDR_IRQSTA, 8'h01);
      tick(3);
      `CHK({overflowReq, irq}, 2'h2)
      wr(tmv_pkg::ADDR_CTRL0, 8'h00);
      tick(3);
      `CHK(overflowReq, 1'b0)
      wr(tmv_pkg::ADDR_CTRL0, 8'h20);
      rd(tmv_pkg::ADDR_STATUS);
      `CHK(q[5], 1'b1)
      wr(tmv_pkg::ADDR_STATUS, 8'h20);
      wr(tmv_pkg::ADDR_STATUS, 8'h00);
      rd(tmv_pkg::ADDR_STATUS);
      `CHK(q[5], 1'b1)
      wr(tmv_pkg::ADDR_STATUS, 8'h00);
      rd(tmv_pkg::ADDR_STATUS);
      `CHK(q[5], 1'b0)
      tick(3);
      `CHK(overflowReq, 1'b0)
      test_done();
   end
endmodule
